// ===== logic/bws_defs.svh
// constants for the bit and word shift register block
`ifndef BWS_DEFS_SVH
`define BWS_DEFS_SVH
// ----------------------------------------------------------------
// memory geometry
// ----------------------------------------------------------------
`define BWS_MEM_WORDS 16
`define BWS_AW 4
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define BWS_OFF_MEM_LAST 7'h3c
`define BWS_OFF_SFT_CTRL 7'h40
`define BWS_OFF_SFT_BND 7'h44
`define BWS_OFF_BID_CTRL 7'h48
`define BWS_OFF_BID_BND 7'h4c
`define BWS_OFF_CMP_CTRL 7'h50
`define BWS_OFF_CMP_BND 7'h54
`define BWS_OFF_STATUS 7'h58
// ----------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------
`define BWS_B_RESET 15
`define BWS_B_SHIFT 14
`define BWS_B_DATA 13
`define BWS_B_BDIR 12
`define BWS_B_CDIR 13
`define BWS_B_BG 8
`define BWS_B_IND 16
// ----------------------------------------------------------------
// status fields and reset values
// ----------------------------------------------------------------
`define BWS_S_FAULT_SFT 0
`define BWS_S_FAULT_BID 1
`define BWS_S_FAULT_CMP 2
`define BWS_S_BIT_OUT 8
`define BWS_CTRL_RST 32'h0000_0000
`define BWS_WORD_RST 16'h0000
`endif

// ===== logic/bws_pkg.sv
// types shared by the shift register block
package bws_pkg;
  typedef enum logic [1:0] {
    BWS_IDLE = 2'b00,
    BWS_RUN = 2'b01,
    BWS_DONE = 2'b10
  } bws_state_e;
  typedef enum logic [2:0] {
    BWS_OP_NONE = 3'b000,
    BWS_OP_CLEAR = 3'b001,
    BWS_OP_SHL = 3'b010,
    BWS_OP_SHR = 3'b011,
    BWS_OP_CMP_LO = 3'b100,
    BWS_OP_CMP_HI = 3'b101
  } bws_op_e;
endpackage

// ===== logic/bws_sync.sv
// three-flop synchroniser for pin level inputs
`timescale 1ns/1ps
`default_nettype none
module bws_sync #(
  parameter int W = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  // chain; output follows only once stages two and three agree
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_o <= '0;
    end else if (ce_i) begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q_o[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // bws_sync
`default_nettype wire

// ===== logic/bws_word_step.sv
// one word step of a shift or compaction pass
`timescale 1ns/1ps
`default_nettype none
`include "bws_defs.svh"
module bws_word_step (
  input wire bws_pkg::bws_op_e op_i,
  input wire logic [15:0] cur_i,
  input wire logic [15:0] nbr_i,
  input wire logic carry_i,
  output logic [15:0] cur_o,
  output logic [15:0] nbr_o,
  output logic carry_o
);
  // new word, neighbour word and carried bit
  always_comb begin
    cur_o = cur_i;
    nbr_o = nbr_i;
    carry_o = carry_i;
    case (op_i)
      bws_pkg::BWS_OP_CLEAR: begin
        cur_o = `BWS_WORD_RST;
        carry_o = 1'b0;
      end
      bws_pkg::BWS_OP_SHL: begin
        cur_o = {cur_i[14:0], carry_i};
        carry_o = cur_i[15];
      end
      bws_pkg::BWS_OP_SHR: begin
        cur_o = {carry_i, cur_i[15:1]};
        carry_o = cur_i[0];
      end
      bws_pkg::BWS_OP_CMP_LO, bws_pkg::BWS_OP_CMP_HI: begin
        if ((cur_i != 16'h0000) && (nbr_i == 16'h0000)) begin
          nbr_o = cur_i;
          cur_o = 16'h0000;
        end
      end
      default: begin
        cur_o = cur_i;
      end
    endcase
  end
endmodule // bws_word_step
`default_nettype wire

// ===== logic/bws_top.sv
// bit and word shift registers over a word memory, avalon-mm slave
`timescale 1ns/1ps
`default_nettype none
`include "bws_defs.svh"
module bws_top (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [6:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [3:0] port_en_i,
  output logic [2:0] fault_flag_o,
  output logic bit_out_flag_o
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;
  // async assert, release through two flops
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [15:0] mem_reg [0:`BWS_MEM_WORDS-1];
  logic [31:0] sft_ctrl_reg;
  logic [31:0] sft_bnd_reg;
  logic [31:0] bid_ctrl_reg;
  logic [31:0] bid_bnd_reg;
  logic [31:0] cmp_ctrl_reg;
  logic [31:0] cmp_bnd_reg;
  bws_pkg::bws_state_e state_reg;
  bws_pkg::bws_op_e op_reg;
  logic [3:0] idx_reg;
  logic [3:0] end_reg;
  logic carry_reg;
  logic src_bid_reg;
  logic rd_ack_reg;
  logic [3:0] port_en_sync;
  logic is_mem;
  logic is_ctrl;
  logic launch;
  logic [31:0] cur_word;
  logic [31:0] new_word;
  bws_pkg::bws_op_e op_next;
  logic [3:0] idx_next;
  logic [3:0] end_next;
  logic carry_next;
  logic [2:0] fault_next;
  logic [3:0] lo4;
  logic [3:0] hi4;
  logic [3:0] nbr_idx;
  logic [15:0] step_cur;
  logic [15:0] step_nbr;
  logic step_carry;
  logic step_last;
  logic step_down;

  // ----------------------------------------------------------------
  // pin synchroniser and word step unit
  // ----------------------------------------------------------------
  bws_sync #(.W(4)) u_port_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_reg),
    .ce_i(ce_i),
    .d_i(port_en_i),
    .q_o(port_en_sync)
  );

  bws_word_step u_step (
    .op_i(op_reg),
    .cur_i(mem_reg[idx_reg]),
    .nbr_i(mem_reg[nbr_idx]),
    .carry_i(carry_reg),
    .cur_o(step_cur),
    .nbr_o(step_nbr),
    .carry_o(step_carry)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign is_mem = (avs_address_i <= `BWS_OFF_MEM_LAST);
  assign is_ctrl = (avs_address_i == `BWS_OFF_SFT_CTRL) ||
                   (avs_address_i == `BWS_OFF_BID_CTRL) ||
                   (avs_address_i == `BWS_OFF_CMP_CTRL);
  assign launch = avs_write_i && is_ctrl && (state_reg == bws_pkg::BWS_IDLE);

  // current value of the addressed register
  always_comb begin
    case (avs_address_i)
      `BWS_OFF_SFT_CTRL: cur_word = sft_ctrl_reg;
      `BWS_OFF_SFT_BND: cur_word = sft_bnd_reg;
      `BWS_OFF_BID_CTRL: cur_word = bid_ctrl_reg;
      `BWS_OFF_BID_BND: cur_word = bid_bnd_reg;
      `BWS_OFF_CMP_CTRL: cur_word = cmp_ctrl_reg;
      `BWS_OFF_CMP_BND: cur_word = cmp_bnd_reg;
      `BWS_OFF_STATUS: cur_word = {23'h000000, bit_out_flag_o, 5'h00, fault_flag_o};
      default: begin
        if (is_mem) begin
          cur_word = {16'h0000, mem_reg[avs_address_i[5:2]]};
        end else begin
          cur_word = 32'h0000_0000;
        end
      end
    endcase
  end

  // byte-enable merge of write data into the current value
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      new_word[b*8 +: 8] = avs_byteenable_i[b] ? avs_writedata_i[b*8 +: 8] : cur_word[b*8 +: 8];
    end
  end

  // reads wait one cycle; control writes wait for the pass to finish
  // a frozen clock enable stalls every request so no write is lost
  always_comb begin
    if (!ce_i) begin
      avs_waitrequest_o = 1'b1;
    end else if (avs_read_i) begin
      avs_waitrequest_o = !rd_ack_reg;
    end else if (avs_write_i) begin
      avs_waitrequest_o = is_ctrl ? (state_reg != bws_pkg::BWS_DONE)
                                  : (state_reg != bws_pkg::BWS_IDLE);
    end else begin
      avs_waitrequest_o = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // launch decision for a control word write
  // ----------------------------------------------------------------
  always_comb begin
    op_next = bws_pkg::BWS_OP_NONE;
    idx_next = 4'h0;
    end_next = 4'h0;
    carry_next = new_word[`BWS_B_DATA];
    fault_next = fault_flag_o;
    lo4 = 4'h0;
    hi4 = 4'h0;
    case (avs_address_i)
      `BWS_OFF_SFT_CTRL: begin
        lo4 = sft_bnd_reg[3:0];
        hi4 = (sft_bnd_reg[3:0] > sft_bnd_reg[11:8]) ? sft_bnd_reg[3:0]
                                                      : sft_bnd_reg[11:8];
        idx_next = lo4;
        end_next = hi4;
        fault_next[`BWS_S_FAULT_SFT] = sft_bnd_reg[`BWS_B_IND] &&
          ((sft_bnd_reg[7:4] != 4'h0) || (sft_bnd_reg[15:12] != 4'h0));
        if (fault_next[`BWS_S_FAULT_SFT]) begin
          op_next = bws_pkg::BWS_OP_NONE;
        end else if (new_word[`BWS_B_RESET]) begin
          op_next = bws_pkg::BWS_OP_CLEAR;
        end else if (new_word[`BWS_B_SHIFT] && !sft_ctrl_reg[`BWS_B_SHIFT]) begin
          op_next = bws_pkg::BWS_OP_SHL;
        end
      end
      `BWS_OFF_BID_CTRL: begin
        lo4 = bid_bnd_reg[3:0];
        hi4 = bid_bnd_reg[11:8];
        fault_next[`BWS_S_FAULT_BID] = (lo4 > hi4);
        idx_next = lo4;
        end_next = hi4;
        if (fault_next[`BWS_S_FAULT_BID]) begin
          op_next = bws_pkg::BWS_OP_NONE;
        end else if (new_word[`BWS_B_RESET]) begin
          op_next = bws_pkg::BWS_OP_CLEAR;
        end else if (new_word[`BWS_B_SHIFT] && !bid_ctrl_reg[`BWS_B_SHIFT]) begin
          if (new_word[`BWS_B_BDIR]) begin
            op_next = bws_pkg::BWS_OP_SHR;
            idx_next = hi4;
            end_next = lo4;
          end else begin
            op_next = bws_pkg::BWS_OP_SHL;
          end
        end
      end
      `BWS_OFF_CMP_CTRL: begin
        lo4 = cmp_bnd_reg[3:0];
        hi4 = cmp_bnd_reg[11:8];
        fault_next[`BWS_S_FAULT_CMP] = (lo4 > hi4) ||
          (new_word[`BWS_B_BG] && !port_en_sync[new_word[1:0]]);
        idx_next = lo4;
        end_next = hi4;
        if (fault_next[`BWS_S_FAULT_CMP]) begin
          op_next = bws_pkg::BWS_OP_NONE;
        end else if (new_word[`BWS_B_RESET]) begin
          op_next = bws_pkg::BWS_OP_CLEAR;
        end else if (new_word[`BWS_B_SHIFT] && (lo4 != hi4)) begin
          if (new_word[`BWS_B_CDIR]) begin
            op_next = bws_pkg::BWS_OP_CMP_LO;
            idx_next = lo4 + 4'h1;
          end else begin
            op_next = bws_pkg::BWS_OP_CMP_HI;
            idx_next = hi4 - 4'h1;
            end_next = lo4;
          end
        end
      end
      default: begin
        op_next = bws_pkg::BWS_OP_NONE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // pass sequencing
  // ----------------------------------------------------------------
  assign step_down = (op_reg == bws_pkg::BWS_OP_SHR) || (op_reg == bws_pkg::BWS_OP_CMP_HI);
  assign step_last = (idx_reg == end_reg);
  // neighbour in the compaction direction
  assign nbr_idx = (op_reg == bws_pkg::BWS_OP_CMP_LO) ? idx_reg - 4'h1 :
                   (op_reg == bws_pkg::BWS_OP_CMP_HI) ? idx_reg + 4'h1 : idx_reg;

  // pass state machine, one word per cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= bws_pkg::BWS_IDLE;
      op_reg <= bws_pkg::BWS_OP_NONE;
      idx_reg <= 4'h0;
      end_reg <= 4'h0;
      carry_reg <= 1'b0;
      src_bid_reg <= 1'b0;
    end else if (ce_i) begin
      case (state_reg)
        bws_pkg::BWS_IDLE: begin
          if (launch) begin
            op_reg <= op_next;
            idx_reg <= idx_next;
            end_reg <= end_next;
            carry_reg <= carry_next;
            src_bid_reg <= (avs_address_i == `BWS_OFF_BID_CTRL);
            state_reg <= (op_next == bws_pkg::BWS_OP_NONE) ? bws_pkg::BWS_DONE
                                                           : bws_pkg::BWS_RUN;
          end
        end
        bws_pkg::BWS_RUN: begin
          carry_reg <= step_carry;
          idx_reg <= step_down ? idx_reg - 4'h1 : idx_reg + 4'h1;
          if (step_last) begin
            state_reg <= bws_pkg::BWS_DONE;
          end
        end
        bws_pkg::BWS_DONE: begin
          op_reg <= bws_pkg::BWS_OP_NONE;
          state_reg <= bws_pkg::BWS_IDLE;
        end
        default: begin
          state_reg <= bws_pkg::BWS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // word memory
  // ----------------------------------------------------------------
  // engine writes neighbour then current word; each word moves at most once
  always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      for (int i = 0; i < `BWS_MEM_WORDS; i++) begin
        mem_reg[i] <= `BWS_WORD_RST;
      end
    end else if (ce_i) begin
      if (state_reg == bws_pkg::BWS_RUN) begin
        mem_reg[nbr_idx] <= step_nbr;
        mem_reg[idx_reg] <= step_cur;
      end else if (avs_write_i && is_mem && (state_reg == bws_pkg::BWS_IDLE)) begin
        mem_reg[avs_address_i[5:2]] <= new_word[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // control, bounds and flag registers
  // ----------------------------------------------------------------
  // control words keep the last written value; the one-bit and bidirectional words use it for edge detection
  always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sft_ctrl_reg <= `BWS_CTRL_RST;
      bid_ctrl_reg <= `BWS_CTRL_RST;
      cmp_ctrl_reg <= `BWS_CTRL_RST;
      sft_bnd_reg <= `BWS_CTRL_RST;
      bid_bnd_reg <= `BWS_CTRL_RST;
      cmp_bnd_reg <= `BWS_CTRL_RST;
    end else if (ce_i && avs_write_i && (state_reg == bws_pkg::BWS_IDLE)) begin
      case (avs_address_i)
        `BWS_OFF_SFT_CTRL: sft_ctrl_reg <= new_word;
        `BWS_OFF_BID_CTRL: bid_ctrl_reg <= new_word;
        `BWS_OFF_CMP_CTRL: cmp_ctrl_reg <= new_word;
        `BWS_OFF_SFT_BND: sft_bnd_reg <= new_word;
        `BWS_OFF_BID_BND: bid_bnd_reg <= new_word;
        `BWS_OFF_CMP_BND: cmp_bnd_reg <= new_word;
        default: begin
          sft_bnd_reg <= sft_bnd_reg;
        end
      endcase
    end
  end

  // each execution rewrites only the fault flag of its own unit
  always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      fault_flag_o <= 3'h0;
    end else if (ce_i && launch) begin
      fault_flag_o <= fault_next;
    end
  end

  // bit-out flag takes the last pushed-out bit of a bidirectional pass
  always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      bit_out_flag_o <= 1'b0;
    end else if (ce_i && (state_reg == bws_pkg::BWS_RUN) && step_last && src_bid_reg) begin
      bit_out_flag_o <= step_carry;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rd_ack_reg <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      rd_ack_reg <= avs_read_i && !rd_ack_reg;
      if (avs_read_i && !rd_ack_reg) begin
        avs_readdata_o <= cur_word;
      end
    end
  end
endmodule // bws_top
`default_nettype wire

// ===== tb/bws_top_chk.sv
// checker for the bit and word shift register block
`timescale 1ns/1ps
`default_nettype none
`include "bws_defs.svh"
module bws_top_chk (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [6:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [3:0] port_en_i,
  input wire logic [2:0] fault_flag_o,
  input wire logic bit_out_flag_o
);
  logic wr_done;
  logic rd_done;
  logic is_ctrl;
  logic [16:0] sft_bnd_reg;
  logic [11:0] bid_bnd_reg;
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  // completed transfers and control decode
  assign wr_done = ce_i && avs_write_i && !avs_waitrequest_o;
  assign rd_done = ce_i && avs_read_i && !avs_waitrequest_o;
  assign is_ctrl = avs_address_i inside {`BWS_OFF_SFT_CTRL, `BWS_OFF_BID_CTRL, `BWS_OFF_CMP_CTRL};
  // shadow copies of the one-bit and bidirectional bound words
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sft_bnd_reg <= 17'h0_0000;
      bid_bnd_reg <= 12'h000;
    end else if (wr_done && avs_address_i == `BWS_OFF_SFT_BND) begin
      sft_bnd_reg <= avs_writedata_i[16:0];
    end else if (wr_done && avs_address_i == `BWS_OFF_BID_BND) begin
      bid_bnd_reg <= avs_writedata_i[11:0];
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  chk_read_one_wait: assert property ($rose(avs_read_i) && ce_i |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read answer not after one wait cycle");
  chk_ctrl_wait_bound: assert property ($rose(avs_write_i) && is_ctrl |-> avs_waitrequest_o ##[1:18] !avs_waitrequest_o)
    else $error("control write not answered in time");
  chk_mem_no_wait: assert property (ce_i && avs_write_i && avs_address_i < 7'h40 |-> !avs_waitrequest_o)
    else $error("memory write stalled");
  chk_rd_unmapped: assert property (rd_done && avs_address_i >= 7'h5c |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_rd_status: assert property (rd_done && avs_address_i == `BWS_OFF_STATUS |-> avs_readdata_o == {23'h0, bit_out_flag_o, 5'h0, fault_flag_o})
    else $error("status read differs from flag pins");
  chk_sft_no_carry: assert property (avs_write_i && avs_address_i == `BWS_OFF_SFT_CTRL |=> $stable(bit_out_flag_o))
    else $error("one-bit shifter changed bit-out flag");
  chk_sft_direct_ok: assert property (wr_done && avs_address_i == `BWS_OFF_SFT_CTRL && !sft_bnd_reg[16] |=> !fault_flag_o[0])
    else $error("one-bit shifter fault on direct bounds");
  chk_sft_ind_fault: assert property (wr_done && avs_address_i == `BWS_OFF_SFT_CTRL && sft_bnd_reg[16] |=> fault_flag_o[0] == (sft_bnd_reg[7:4] != 4'h0 || sft_bnd_reg[15:12] != 4'h0))
    else $error("one-bit shifter indirect fault wrong");
  chk_bid_fault: assert property (wr_done && avs_address_i == `BWS_OFF_BID_CTRL |=> fault_flag_o[1] == (bid_bnd_reg[3:0] > bid_bnd_reg[11:8]))
    else $error("bidirectional fault flag wrong");
  chk_bid_clear: assert property (wr_done && avs_address_i == `BWS_OFF_BID_CTRL && avs_writedata_i[15] |=> !bit_out_flag_o)
    else $error("bit-out flag not cleared");
  chk_flag_hold: assert property (!$past(avs_write_i && is_ctrl) |-> $stable({fault_flag_o, bit_out_flag_o}))
    else $error("flags changed without execution");
  cov_bid_carry: cover property (wr_done && avs_address_i == `BWS_OFF_BID_CTRL ##1 bit_out_flag_o);
  cov_cmp_fault: cover property (wr_done && avs_address_i == `BWS_OFF_CMP_CTRL ##1 fault_flag_o[2]);
  cov_long_wait: cover property (avs_write_i && is_ctrl && avs_waitrequest_o [*6]);
endmodule // bws_top_chk
bind bws_top bws_top_chk u_chk (.clk_sys_i, .nrst_i, .ce_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
  .port_en_i, .fault_flag_o, .bit_out_flag_o);
`default_nettype wire

// ===== tb/tb_bws_top.sv
// self-checking testbench for the bit and word shift register block
`timescale 1ns/1ps
`default_nettype none
`include "bws_defs.svh"
module tb_bws_top;
  logic clk_sys_i, nrst_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o, bit_out_flag_o;
  logic [6:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [3:0] avs_byteenable_i, port_en_i, ef;
  logic [2:0] fault_flag_o;
  logic [15:0] em [16];
  int err_total, cmp_count;
  bws_top dut (.clk_sys_i, .nrst_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .port_en_i,
    .fault_flag_o, .bit_out_flag_o);
  // ----------------------------------------------------------------
  // clock, checks and bus
  // ----------------------------------------------------------------
  // free-running 125 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp_word(input string w, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", w, e, g);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  // a hang is cut short by the watchdog, not here
  task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_sys_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic put(input int i, input logic [15:0] v);
    em[i] = v;
    bus(1'b1, 7'(i * 4), {16'hffff, v});
  endtask
  // reads back every word, the status word and the flag pins
  task automatic check_mem;
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, 7'(i * 4), 32'h0);
      cmp_word("memory word", {16'h0, em[i]}, rd);
    end
    bus(1'b0, `BWS_OFF_STATUS, 32'h0);
    cmp_word("status", {23'h0, ef[0], 5'h0, ef[3:1]}, rd);
    cmp_word("flag pins", {28'h0, ef}, {28'h0, fault_flag_o, bit_out_flag_o});
  endtask
  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  function automatic logic shl(input int lo, input int hi, input logic din);
    logic c;
    c = em[hi][15];
    for (int i = hi; i > lo; i--)
      em[i] = {em[i][14:0], em[i-1][15]};
    em[lo] = {em[lo][14:0], din};
    return c;
  endfunction
  function automatic logic shr(input int lo, input int hi, input logic din);
    logic c;
    c = em[lo][0];
    for (int i = lo; i < hi; i++)
      em[i] = {em[i+1][0], em[i][15:1]};
    em[hi] = {din, em[hi][15:1]};
    return c;
  endfunction
  // each word moves one place at most, walking from the destination end
  function automatic void pack(input int lo, input int hi, input logic tolo);
    int j;
    for (int k = 0; k < hi - lo; k++) begin
      j = tolo ? lo + 1 + k : hi - 1 - k;
      if (em[j] != 16'h0 && em[tolo ? j - 1 : j + 1] == 16'h0) begin
        em[tolo ? j - 1 : j + 1] = em[j];
        em[j] = 16'h0;
      end
    end
  endfunction
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 16; i++)
      put(i, 16'(16'h1357 * (i + 1)));
    // a write issued while the clock enable is low must stall, then land
    fork
      put(0, 16'h5a5a);
      begin
        ce_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        cmp_word("frozen stall", 32'h1, {31'h0, avs_waitrequest_o});
        ce_i <= 1'b1;
      end
    join
    // only the low byte lane is written
    avs_byteenable_i <= 4'h1;
    em[1][7:0] = 8'h3c;
    bus(1'b1, 7'h04, 32'hffff_a53c);
    avs_byteenable_i <= 4'hf;
    bus(1'b1, `BWS_OFF_STATUS, 32'hffff_ffff);
    bus(1'b1, 7'h5c, 32'hffff_ffff);
    bus(1'b0, 7'h5c, 32'h0);
    cmp_word("unmapped read", 32'h0, rd);
    check_mem;
    $display("test regs done");
  endtask
  task automatic t_sft;
    put(3, 16'h8001);
    bus(1'b1, `BWS_OFF_SFT_BND, 32'h0000_0301);
    bus(1'b1, `BWS_OFF_SFT_CTRL, 32'h0);
    bus(1'b1, `BWS_OFF_SFT_CTRL, 32'h6000);
    void'(shl(1, 3, 1'b1));
    check_mem;
    bus(1'b1, `BWS_OFF_SFT_CTRL, 32'h6000);
    check_mem;
    bus(1'b1, `BWS_OFF_SFT_CTRL, 32'he000);
    for (int i = 1; i < 4; i++)
      em[i] = 16'h0;
    check_mem;
    bus(1'b1, `BWS_OFF_SFT_BND, 32'h0000_0205);
    bus(1'b1, `BWS_OFF_SFT_CTRL, 32'h0);
    bus(1'b1, `BWS_OFF_SFT_CTRL, 32'h6000);
    void'(shl(5, 5, 1'b1));
    check_mem;
    bus(1'b1, `BWS_OFF_SFT_BND, 32'h0001_0031);
    bus(1'b1, `BWS_OFF_SFT_CTRL, 32'h0);
    bus(1'b1, `BWS_OFF_SFT_CTRL, 32'h6000);
    ef[1] = 1'b1;
    check_mem;
    bus(1'b1, `BWS_OFF_SFT_BND, 32'h0001_0301);
    bus(1'b1, `BWS_OFF_SFT_CTRL, 32'h0);
    bus(1'b1, `BWS_OFF_SFT_CTRL, 32'h6000);
    void'(shl(1, 3, 1'b1));
    ef[1] = 1'b0;
    check_mem;
    $display("test one-bit shifter done");
  endtask
  task automatic t_bid;
    logic [1:0] stp [5];
    stp = '{2'b01, 2'b10, 2'b00, 2'b11, 2'b00};
    put(2, 16'h0001);
    put(3, 16'h8000);
    bus(1'b1, `BWS_OFF_BID_BND, 32'h0000_0302);
    // each step is {direction, data in}
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, `BWS_OFF_BID_CTRL, 32'h0);
      bus(1'b1, `BWS_OFF_BID_CTRL, {16'h0, 2'b01, stp[k][0], stp[k][1], 12'h0});
      ef[0] = stp[k][1] ? shr(2, 3, stp[k][0]) : shl(2, 3, stp[k][0]);
      check_mem;
    end
    bus(1'b1, `BWS_OFF_BID_CTRL, 32'he000);
    em[2] = 16'h0;
    em[3] = 16'h0;
    ef[0] = 1'b0;
    check_mem;
    bus(1'b1, `BWS_OFF_BID_BND, 32'h0000_0203);
    bus(1'b1, `BWS_OFF_BID_CTRL, 32'h0);
    ef[2] = 1'b1;
    check_mem;
    bus(1'b1, `BWS_OFF_BID_BND, 32'h0000_0302);
    bus(1'b1, `BWS_OFF_BID_CTRL, 32'h0);
    ef[2] = 1'b0;
    check_mem;
    $display("test bidirectional shifter done");
  endtask
  task automatic t_cmp;
    put(3, 16'h0);
    put(4, 16'h00a1);
    put(5, 16'h0);
    put(6, 16'h00b2);
    put(7, 16'h0);
    put(8, 16'h0);
    put(9, 16'h00c3);
    put(10, 16'h0f0f);
    bus(1'b1, `BWS_OFF_CMP_BND, 32'h0000_0904);
    bus(1'b1, `BWS_OFF_CMP_CTRL, 32'h4000);
    pack(4, 9, 1'b0);
    check_mem;
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, `BWS_OFF_CMP_CTRL, 32'h6000);
      pack(4, 9, 1'b1);
      check_mem;
    end
    bus(1'b1, `BWS_OFF_CMP_CTRL, 32'h0102);
    ef[3] = 1'b1;
    check_mem;
    bus(1'b1, `BWS_OFF_CMP_CTRL, 32'h0103);
    ef[3] = 1'b0;
    check_mem;
    bus(1'b1, `BWS_OFF_CMP_CTRL, 32'hc000);
    for (int i = 4; i < 10; i++)
      em[i] = 16'h0;
    check_mem;
    bus(1'b1, `BWS_OFF_CMP_BND, 32'h0000_0409);
    bus(1'b1, `BWS_OFF_CMP_CTRL, 32'h0);
    ef[3] = 1'b1;
    check_mem;
    $display("test compactor done");
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    nrst_i = 1'b0;
    ce_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 7'h00;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    port_en_i = 4'hb;
    ef = 4'h0;
    err_total = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    t_regs;
    t_sft;
    t_bid;
    t_cmp;
    stop_test;
  end
  // cuts a hang short well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    err_total++;
    $display("watchdog expired");
    stop_test;
  end
endmodule // tb_bws_top
`default_nettype wire
